// ===== verilog/dlsc_defs.svh
// Constants of the dual supply control register bank: offsets, fields, timing.
// Assumes a 20 MHz system clock; included by the package and the design files.
`ifndef DLSC_DEFS_SVH
`define DLSC_DEFS_SVH

// ----------------------------------------------------------------
// Bus address and register offsets
// ----------------------------------------------------------------
// Arbitrary value; the board selects the real one
`define DLSC_I2C_ADDR        7'h08
`define DLSC_REG_VSEL        8'h02
`define DLSC_REG_TPC         8'h03
`define DLSC_REG_CLC         8'h04
`define DLSC_DATA_RST        8'h00
`define DLSC_READ_NONE       8'h00

// ----------------------------------------------------------------
// Field positions (channel A nibble; channel B adds the shift)
// ----------------------------------------------------------------
`define DLSC_CH_B_SHIFT      4
`define DLSC_TONE_ON_BIT     0
`define DLSC_LOW_POWER_BIT   1
`define DLSC_KIND_BIT        2
`define DLSC_RANGE_BIT       0
`define DLSC_BOOST_BIT       1
`define DLSC_PULSED_OFF_BIT  2
`define DLSC_ON_LONG_BIT     3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DLSC_CLK_HZ          20000000
`define DLSC_TONE_HZ         22000
`define DLSC_TONE_HALF_CYC   (`DLSC_CLK_HZ / (2 * `DLSC_TONE_HZ))
`define DLSC_TONE_W          9
`define DLSC_ON_LONG_MS      180
`define DLSC_ON_SHORT_MS     90
`define DLSC_ON_LONG_CYC     (`DLSC_ON_LONG_MS * (`DLSC_CLK_HZ / 1000))
`define DLSC_ON_SHORT_CYC    (`DLSC_ON_SHORT_MS * (`DLSC_CLK_HZ / 1000))
`define DLSC_TIMER_W         23

`endif

// ===== verilog/dlsc_pkg.sv
// Types of the dual supply control register bank.
// Assumes dlsc_defs.svh is on the include path.
`include "dlsc_defs.svh"

package dlsc_pkg;

  // ----------------------------------------------------------------
  // Serial slave states
  // ----------------------------------------------------------------
  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_ADDR  = 9'h002,
    ST_ACKA  = 9'h004,
    ST_REG   = 9'h008,
    ST_ACKR  = 9'h010,
    ST_WDATA = 9'h020,
    ST_ACKW  = 9'h040,
    ST_RDATA = 9'h080,
    ST_RACK  = 9'h100
  } dlsc_state_type;

  // ----------------------------------------------------------------
  // Module state records
  // ----------------------------------------------------------------
  typedef struct packed {
    dlsc_state_type st;
    logic [3:0]     cnt;
    logic [7:0]     sh;
    logic [7:0]     ptr;
    logic           rw;
    logic           more;
    logic [7:0]     vsel;
    logic [7:0]     tpc;
    logic [7:0]     clc;
    logic           sda_oe;
    logic [1:0]     scl_s;
    logic [1:0]     sda_s;
    logic           scl_d;
    logic           sda_d;
    logic [1:0]     tin_a;
    logic [1:0]     tin_b;
    logic [1:0]     ovl_a;
    logic [1:0]     ovl_b;
  } dlsc_top_type;

  typedef struct packed {
    logic [`DLSC_TONE_W-1:0]  tone_cnt;
    logic                     phase;
    logic [`DLSC_TIMER_W-1:0] timer;
    logic                     tone_out;
    logic                     limit_on;
  } dlsc_chan_type;

endpackage

// ===== verilog/dlsc_chan_if.sv
// Per-channel settings from the register bank and results back from the channel.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns

interface dlsc_chan_if;
  logic tone_on;
  logic kind;
  logic pulsed_off;
  logic on_long;
  logic tone_in;
  logic overload;
  logic tone_out;
  logic limit_on;

  modport ctl (output tone_on, output kind, output pulsed_off, output on_long,
               output tone_in, output overload, input tone_out, input limit_on);
  modport chn (input tone_on, input kind, input pulsed_off, input on_long,
               input tone_in, input overload, output tone_out, output limit_on);
endinterface

// ===== verilog/dlsc_chan.sv
// One supply channel: tone gating and pulsed output current limit timing.
// Assumes tone_in and overload already synchronised to clk.
`timescale 1ns/1ns
`include "dlsc_defs.svh"

module dlsc_chan #(
  parameter logic [`DLSC_TIMER_W-1:0] ON_LONG_CYC  = `DLSC_TIMER_W'(`DLSC_ON_LONG_CYC),
  parameter logic [`DLSC_TIMER_W-1:0] ON_SHORT_CYC = `DLSC_TIMER_W'(`DLSC_ON_SHORT_CYC)
) (
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  reset_n,
  // Channel link
  dlsc_chan_if.chn   ch
);
  import dlsc_pkg::*;

  localparam logic [`DLSC_TONE_W-1:0] TONE_LAST = `DLSC_TONE_W'(`DLSC_TONE_HALF_CYC - 1);
  localparam dlsc_chan_type CHAN_RST = '0;

  dlsc_chan_type q;
  dlsc_chan_type d;

  assign ch.tone_out = q.tone_out;
  assign ch.limit_on = q.limit_on;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    // Free running carrier, so envelope bursts start at any point of its phase
    if (q.tone_cnt == TONE_LAST) begin
      d.tone_cnt = '0;
      d.phase    = ~q.phase;
    end else begin
      d.tone_cnt = q.tone_cnt + `DLSC_TONE_W'(1);
    end
    d.tone_out = ch.tone_on & (ch.kind ? ch.tone_in : (ch.tone_in & q.phase));
    if (ch.pulsed_off) begin
      d.timer    = '0;
      d.limit_on = ch.overload;
    end else if (q.timer != '0) begin
      d.timer    = q.timer - `DLSC_TIMER_W'(1);
      d.limit_on = 1'b1;
    end else if (ch.overload) begin
      // No off interval here: limit stays held while overload persists
      d.timer    = ch.on_long ? (ON_LONG_CYC - `DLSC_TIMER_W'(1)) : (ON_SHORT_CYC - `DLSC_TIMER_W'(1));
      d.limit_on = 1'b1;
    end else begin
      d.limit_on = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q <= CHAN_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_limit_hold: assert property ((q.timer != '0 && !ch.pulsed_off) |=> q.limit_on)
    else $error("pulsed limit dropped before on interval ended");
  a_limit_bypass: assert property (ch.pulsed_off |=> q.limit_on == $past(ch.overload))
    else $error("limit does not follow overload with pulsing off");
  a_on_long_load: assert property ((!ch.pulsed_off && q.timer == '0 && ch.overload && ch.on_long)
    |=> q.timer == ON_LONG_CYC - `DLSC_TIMER_W'(1))
    else $error("long on interval not loaded");
  a_on_short_load: assert property ((!ch.pulsed_off && q.timer == '0 && ch.overload && !ch.on_long)
    |=> q.timer == ON_SHORT_CYC - `DLSC_TIMER_W'(1))
    else $error("short on interval not loaded");
  c_limit_pulse: cover property (!q.limit_on ##1 q.limit_on ##1 q.timer != '0);
endmodule

// ===== verilog/dlsc_top.sv
// Dual supply control register bank reached over a two-wire serial slave.
// Assumes scl, sda and the channel pins are asynchronous; sda wire resolved outside.
`timescale 1ns/1ns
`include "dlsc_defs.svh"

module dlsc_top #(
  parameter logic [`DLSC_TIMER_W-1:0] ON_LONG_CYC  = `DLSC_TIMER_W'(`DLSC_ON_LONG_CYC),
  parameter logic [`DLSC_TIMER_W-1:0] ON_SHORT_CYC = `DLSC_TIMER_W'(`DLSC_ON_SHORT_CYC),
  parameter logic [6:0]               I2C_ADDR     = `DLSC_I2C_ADDR
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Serial bus
  input  wire logic        scl,
  input  wire logic        sda_line,
  output logic             sda_drive,
  output logic             sda_oe,
  // Channel pins
  input  wire logic        tone_control_input_a,
  input  wire logic        tone_control_input_b,
  input  wire logic        overload_a,
  input  wire logic        overload_b,
  // Channel A controls
  output logic [3:0]       volt_code_a,
  output logic             tone_out_a,
  output logic             low_power_a,
  output logic             tone_input_kind_a,
  output logic             out_limit_range_a,
  output logic             boost_limit_sel_a,
  output logic             pulsed_limit_off_a,
  output logic             limit_on_a,
  // Channel B controls
  output logic [3:0]       volt_code_b,
  output logic             tone_out_b,
  output logic             low_power_b,
  output logic             tone_input_kind_b,
  output logic             out_limit_range_b,
  output logic             boost_limit_sel_b,
  output logic             pulsed_limit_off_b,
  output logic             limit_on_b
);
  import dlsc_pkg::*;

  localparam int B = `DLSC_CH_B_SHIFT;
  localparam dlsc_top_type TOP_RST = '{
    st: ST_IDLE, cnt: 4'h0, sh: 8'h00, ptr: 8'h00, rw: 1'b0, more: 1'b0,
    vsel: `DLSC_DATA_RST, tpc: `DLSC_DATA_RST, clc: `DLSC_DATA_RST, sda_oe: 1'b0,
    scl_s: 2'h3, sda_s: 2'h3, scl_d: 1'b1, sda_d: 1'b1,
    tin_a: 2'h0, tin_b: 2'h0, ovl_a: 2'h0, ovl_b: 2'h0};

  dlsc_top_type q;
  dlsc_top_type d;
  logic         scl_rise;
  logic         scl_fall;
  logic         start_seen;
  logic         stop_seen;
  logic         wr_en;
  logic [7:0]   nb;

  dlsc_chan_if ch_a();
  dlsc_chan_if ch_b();

  function automatic logic [7:0] rd_byte(input logic [7:0] a, input dlsc_top_type s);
    case (a)
      `DLSC_REG_VSEL: rd_byte = s.vsel;
      `DLSC_REG_TPC:  rd_byte = s.tpc;
      `DLSC_REG_CLC:  rd_byte = s.clc;
      default:        rd_byte = `DLSC_READ_NONE;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Bus events, from the second synchroniser stage only
  // ----------------------------------------------------------------
  assign scl_rise   = q.scl_s[1] & ~q.scl_d;
  assign scl_fall   = ~q.scl_s[1] & q.scl_d;
  assign start_seen = q.scl_s[1] & q.scl_d & q.sda_d & ~q.sda_s[1];
  assign stop_seen  = q.scl_s[1] & q.scl_d & ~q.sda_d & q.sda_s[1];
  assign nb         = rd_byte((q.st == ST_RACK) ? q.ptr + 8'h01 : q.ptr, q);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d       = q;
    wr_en   = 1'b0;
    d.scl_s = {q.scl_s[0], scl};
    d.sda_s = {q.sda_s[0], sda_line};
    d.scl_d = q.scl_s[1];
    d.sda_d = q.sda_s[1];
    d.tin_a = {q.tin_a[0], tone_control_input_a};
    d.tin_b = {q.tin_b[0], tone_control_input_b};
    d.ovl_a = {q.ovl_a[0], overload_a};
    d.ovl_b = {q.ovl_b[0], overload_b};
    case (q.st)
      ST_ADDR, ST_REG, ST_WDATA: begin
        if (scl_rise && q.cnt != 4'h8) begin
          d.sh  = {q.sh[6:0], q.sda_s[1]};
          d.cnt = q.cnt + 4'h1;
        end else if (scl_fall && q.cnt == 4'h8) begin
          d.cnt = 4'h0;
          if (q.st == ST_ADDR) begin
            if (q.sh[7:1] == I2C_ADDR) begin
              d.st     = ST_ACKA;
              d.rw     = q.sh[0];
              d.sda_oe = 1'b1;
            end else begin
              d.st = ST_IDLE;
            end
          end else if (q.st == ST_REG) begin
            d.ptr    = q.sh;
            d.st     = ST_ACKR;
            d.sda_oe = 1'b1;
          end else begin
            wr_en    = 1'b1;
            d.ptr    = q.ptr + 8'h01;
            d.st     = ST_ACKW;
            d.sda_oe = 1'b1;
          end
        end
      end
      ST_ACKA, ST_ACKR, ST_ACKW: begin
        if (scl_fall) begin
          d.sda_oe = 1'b0;
          d.cnt    = 4'h0;
          if (q.st == ST_ACKA && q.rw) begin
            d.sh     = nb;
            d.st     = ST_RDATA;
            d.sda_oe = ~nb[7];
          end else if (q.st == ST_ACKA) begin
            d.st = ST_REG;
          end else begin
            d.st = ST_WDATA;
          end
        end
      end
      ST_RDATA: begin
        if (scl_rise) begin
          d.cnt = q.cnt + 4'h1;
        end else if (scl_fall && q.cnt == 4'h8) begin
          d.sda_oe = 1'b0;
          d.st     = ST_RACK;
        end else if (scl_fall) begin
          d.sda_oe = ~q.sh[3'(4'h7 - q.cnt)];
        end
      end
      ST_RACK: begin
        if (scl_rise) begin
          d.more = ~q.sda_s[1];
        end else if (scl_fall && q.more) begin
          d.ptr    = q.ptr + 8'h01;
          d.sh     = nb;
          d.cnt    = 4'h0;
          d.st     = ST_RDATA;
          d.sda_oe = ~nb[7];
        end else if (scl_fall) begin
          d.st = ST_IDLE;
        end
      end
      ST_IDLE: begin
      end
      default: begin
        d.st     = ST_IDLE;
        d.sda_oe = 1'b0;
      end
    endcase
    // Whole byte stored as sent, reserved bits included
    if (wr_en) begin
      case (q.ptr)
        `DLSC_REG_VSEL: d.vsel = q.sh;
        `DLSC_REG_TPC:  d.tpc  = q.sh;
        `DLSC_REG_CLC:  d.clc  = q.sh;
        default: begin
        end
      endcase
    end
    if (start_seen) begin
      d.st     = ST_ADDR;
      d.cnt    = 4'h0;
      d.sda_oe = 1'b0;
    end else if (stop_seen) begin
      d.st     = ST_IDLE;
      d.sda_oe = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q <= TOP_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Channels and outputs
  // ----------------------------------------------------------------
  assign ch_a.tone_on    = q.tpc[`DLSC_TONE_ON_BIT];
  assign ch_a.kind       = q.tpc[`DLSC_KIND_BIT];
  assign ch_a.pulsed_off = q.clc[`DLSC_PULSED_OFF_BIT];
  assign ch_a.on_long    = q.clc[`DLSC_ON_LONG_BIT];
  assign ch_a.tone_in    = q.tin_a[1];
  assign ch_a.overload   = q.ovl_a[1];
  assign ch_b.tone_on    = q.tpc[B + `DLSC_TONE_ON_BIT];
  assign ch_b.kind       = q.tpc[B + `DLSC_KIND_BIT];
  assign ch_b.pulsed_off = q.clc[B + `DLSC_PULSED_OFF_BIT];
  assign ch_b.on_long    = q.clc[B + `DLSC_ON_LONG_BIT];
  assign ch_b.tone_in    = q.tin_b[1];
  assign ch_b.overload   = q.ovl_b[1];

  dlsc_chan #(.ON_LONG_CYC(ON_LONG_CYC), .ON_SHORT_CYC(ON_SHORT_CYC)) u_chan_a (
    .clk(clk), .reset_n(reset_n), .ch(ch_a.chn));
  dlsc_chan #(.ON_LONG_CYC(ON_LONG_CYC), .ON_SHORT_CYC(ON_SHORT_CYC)) u_chan_b (
    .clk(clk), .reset_n(reset_n), .ch(ch_b.chn));

  // Open-drain: only ever pulls low
  assign sda_drive          = 1'b0;
  assign sda_oe             = q.sda_oe;
  assign volt_code_a        = q.vsel[3:0];
  assign volt_code_b        = q.vsel[7:4];
  assign tone_out_a         = ch_a.tone_out;
  assign tone_out_b         = ch_b.tone_out;
  // Low power is not blocked during tone; host keeps the two apart
  assign low_power_a        = q.tpc[`DLSC_LOW_POWER_BIT];
  assign low_power_b        = q.tpc[B + `DLSC_LOW_POWER_BIT];
  assign tone_input_kind_a  = q.tpc[`DLSC_KIND_BIT];
  assign tone_input_kind_b  = q.tpc[B + `DLSC_KIND_BIT];
  assign out_limit_range_a  = q.clc[`DLSC_RANGE_BIT];
  assign out_limit_range_b  = q.clc[B + `DLSC_RANGE_BIT];
  assign boost_limit_sel_a  = q.clc[`DLSC_BOOST_BIT];
  assign boost_limit_sel_b  = q.clc[B + `DLSC_BOOST_BIT];
  assign pulsed_limit_off_a = q.clc[`DLSC_PULSED_OFF_BIT];
  assign pulsed_limit_off_b = q.clc[B + `DLSC_PULSED_OFF_BIT];
  assign limit_on_a         = ch_a.limit_on;
  assign limit_on_b         = ch_b.limit_on;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_write_tpc: assert property ((wr_en && q.ptr == `DLSC_REG_TPC) |=> (q.tpc == $past(q.sh)))
    else $error("tone control register not written");
  a_write_incr: assert property (wr_en |=> (q.ptr == $past(q.ptr) + 8'h01 && q.st == ST_ACKW))
    else $error("write address did not advance");
  a_read_load: assert property ((q.st == ST_ACKA && q.rw && scl_fall && !start_seen && !stop_seen)
    |=> (q.st == ST_RDATA && q.sh == rd_byte($past(q.ptr), $past(q))))
    else $error("read byte differs from register");
  a_ack_drive: assert property ((q.st == ST_ACKA || q.st == ST_ACKR || q.st == ST_ACKW) |-> q.sda_oe)
    else $error("acknowledge not driven");
  a_stop_idle: assert property (stop_seen |=> (q.st == ST_IDLE && !q.sda_oe))
    else $error("stop did not release bus");
  a_tone_off: assert property (!q.tpc[`DLSC_TONE_ON_BIT] |=> !tone_out_a)
    else $error("tone output while disabled");
  a_tone_follow: assert property ((q.tpc[`DLSC_TONE_ON_BIT] && q.tpc[`DLSC_KIND_BIT])
    |=> tone_out_a == $past(q.tin_a[1]))
    else $error("tone output does not follow input");
  a_env_gate: assert property ((q.tpc[B + `DLSC_TONE_ON_BIT] && !q.tpc[B + `DLSC_KIND_BIT] && !q.tin_b[1])
    |=> !tone_out_b)
    else $error("tone output outside envelope");

  c_write_three: cover property (wr_en && q.ptr == `DLSC_REG_CLC);
  c_read_more: cover property (q.st == ST_RACK && q.more && scl_fall);
  c_tone_a: cover property (tone_out_a ##1 !tone_out_a);
endmodule

// ===== sim/dlsc_host.sv
// Two-wire bus master standing in for the host processor.
// Assumes the bench resolves sda from sda_rel and the slave drive, with a pull-up.
`timescale 1ns/1ns

module dlsc_host (
  // Clock
  input  wire logic clk,
  // Bus
  output logic      scl,
  output logic      sda_rel,
  input  wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end

  // --------------------
  // Bit level
  // --------------------
  // Phases of 5 clk, well above the 4 clk minimum
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask

  task automatic bit_io(input logic b, output logic r);
    tick(5);
    sda_rel = b;
    tick(5);
    scl = 1'b1;
    tick(5);
    r = sda;
    tick(5);
    scl = 1'b0;
  endtask

  task automatic start();
    sda_rel = 1'b1;
    tick(5);
    scl = 1'b1;
    tick(5);
    sda_rel = 1'b0;
    tick(5);
    scl = 1'b0;
  endtask

  task automatic stop();
    tick(5);
    sda_rel = 1'b0;
    tick(5);
    scl = 1'b1;
    tick(5);
    sda_rel = 1'b1;
    tick(5);
  endtask

  task automatic byte_io(input logic [7:0] tx, input logic ak, output logic [7:0] rx, output logic nak);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ak, nak);
  endtask

  // --------------------
  // Transfers
  // --------------------
  // Bytes in d go out lowest first; a stop always ends the transfer
  task automatic wr(input logic [6:0] dev, input logic [7:0] ra, input logic [23:0] d, input int n,
                    output logic nak);
    logic [7:0] rx;
    logic       a;
    start();
    byte_io({dev, 1'b0}, 1'b1, rx, nak);
    byte_io(ra, 1'b1, rx, a);
    nak |= a;
    for (int i = 0; i < n; i++) begin
      byte_io(d[8*i +: 8], 1'b1, rx, a);
      nak |= a;
    end
    stop();
  endtask

  task automatic rd(input logic [6:0] dev, input logic [7:0] ra, input int n, output logic [23:0] d,
                    output logic nak);
    logic [7:0] rx;
    logic       a;
    d = 24'h0;
    start();
    byte_io({dev, 1'b0}, 1'b1, rx, nak);
    byte_io(ra, 1'b1, rx, a);
    nak |= a;
    stop();
    start();
    byte_io({dev, 1'b1}, 1'b1, rx, a);
    nak |= a;
    for (int i = 0; i < n; i++) begin
      byte_io(8'hff, (i == n - 1), rx, a);
      d[8*i +: 8] = rx;
    end
    stop();
  endtask
endmodule

// ===== sim/tb_dlsc_top.sv
// Self-checking bench for the supply control register bank.
// Assumes dlsc_host as bus master and a pull-up on the data wire.
`timescale 1ns/1ns
`include "dlsc_defs.svh"

module tb_dlsc_top;
  localparam int         LONG  = 40;
  localparam int         SHORT = 20;
  localparam logic [6:0] DEV   = `DLSC_I2C_ADDR;

  logic       clk;
  logic       reset_n;
  logic       scl;
  logic       sda_rel;
  logic       sda_drive;
  logic       sda_oe;
  logic       sda;
  logic       tin_a;
  logic       tin_b;
  logic       ovl_a;
  logic       ovl_b;
  logic [3:0] va;
  logic [3:0] vb;
  logic       to_a, to_b, lp_a, lp_b, kd_a, kd_b, rg_a, rg_b, bs_a, bs_b, po_a, po_b, lo_a, lo_b;
  int         bad_count = 0;
  int         checks = 0;
  logic [7:0] fv [2] = '{8'h96, 8'h69};
  logic [7:0] cv [3] = '{8'h08, 8'h80, 8'h44};
  int         ea [3] = '{LONG, SHORT, 1};
  int         eb [3] = '{SHORT, LONG, 1};

  // Open-drain wire with pull-up
  assign sda = sda_rel & (~sda_oe | sda_drive);

  initial begin
    clk = 1'b0;
  end
  always #25 clk = ~clk;

  dlsc_host dlsc_host_i (.clk(clk), .scl(scl), .sda_rel(sda_rel), .sda(sda));

  dlsc_top #(
    .ON_LONG_CYC  (`DLSC_TIMER_W'(LONG)),
    .ON_SHORT_CYC (`DLSC_TIMER_W'(SHORT)),
    .I2C_ADDR     (DEV)
  ) dlsc_top_i (
    .clk(clk), .reset_n(reset_n), .scl(scl), .sda_line(sda), .sda_drive(sda_drive), .sda_oe(sda_oe),
    .tone_control_input_a(tin_a), .tone_control_input_b(tin_b), .overload_a(ovl_a), .overload_b(ovl_b),
    .volt_code_a(va), .tone_out_a(to_a), .low_power_a(lp_a), .tone_input_kind_a(kd_a),
    .out_limit_range_a(rg_a), .boost_limit_sel_a(bs_a), .pulsed_limit_off_a(po_a), .limit_on_a(lo_a),
    .volt_code_b(vb), .tone_out_b(to_b), .low_power_b(lp_b), .tone_input_kind_b(kd_b),
    .out_limit_range_b(rg_b), .boost_limit_sel_b(bs_b), .pulsed_limit_off_b(po_b), .limit_on_b(lo_b)
  );

  // --------------------
  // Tasks
  // --------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wrc(input logic [7:0] ra, input logic [23:0] d, input int n);
    logic nak;
    dlsc_host_i.wr(DEV, ra, d, n, nak);
    chk(24'(nak), 24'h0);
  endtask

  task automatic rdc(input logic [7:0] ra, input int n, input logic [23:0] exp);
    logic [23:0] d;
    logic        nak;
    dlsc_host_i.rd(DEV, ra, n, d, nak);
    chk(24'(nak), 24'h0);
    chk(d, exp);
  endtask

  // One-clock overload, then count limit cycles per channel
  task automatic pulse(output int ca, output int cb);
    ca = 0;
    cb = 0;
    ovl_a = 1'b1;
    ovl_b = 1'b1;
    cyc(1);
    ovl_a = 1'b0;
    ovl_b = 1'b0;
    repeat (100) begin
      cyc(1);
      ca += int'(lo_a);
      cb += int'(lo_b);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // --------------------
  // Tests
  // --------------------
  initial begin
    int         n;
    int         ca;
    int         cb;
    logic       nak;
    logic [23:0] d;
    reset_n = 1'b0;
    tin_a = 1'b0;
    tin_b = 1'b0;
    ovl_a = 1'b0;
    ovl_b = 1'b0;
    cyc(8);
    reset_n = 1'b1;
    cyc(4);
    rdc(8'h02, 3, 24'h0);
    $display("test reset done");
    wrc(8'h02, 24'h00555a, 3);
    chk(24'({vb, va}), 24'h5a);
    rdc(8'h02, 3, 24'h00555a);
    $display("test burst done");
    tin_a = 1'b1;
    cyc(5);
    chk(24'({lp_b, kd_b, to_b, lp_a, kd_a, to_a}), 24'h13);
    tin_a = 1'b0;
    tin_b = 1'b1;
    cyc(5);
    chk(24'({lp_b, kd_b, to_b, lp_a, kd_a, to_a}), 24'h1a);
    wrc(8'h03, 24'h11, 1);
    tin_a = 1'b1;
    cyc(5);
    n = 0;
    // One full carrier period: high for exactly one half period
    repeat (2 * `DLSC_TONE_HALF_CYC) begin
      cyc(1);
      n += int'(to_a);
    end
    chk(24'(n), 24'(`DLSC_TONE_HALF_CYC));
    wrc(8'h03, 24'h22, 1);
    cyc(5);
    chk(24'({lp_b, kd_b, to_b, lp_a, kd_a, to_a}), 24'h24);
    $display("test tone done");
    foreach (fv[i]) begin
      wrc(8'h04, 24'(fv[i]), 1);
      chk(24'({po_b, bs_b, rg_b, po_a, bs_a, rg_a}), 24'({fv[i][6:4], fv[i][2:0]}));
    end
    foreach (cv[i]) begin
      wrc(8'h04, 24'(cv[i]), 1);
      pulse(ca, cb);
      chk(24'(ca), 24'(ea[i]));
      chk(24'(cb), 24'(eb[i]));
    end
    $display("test limit done");
    dlsc_host_i.wr(DEV ^ 7'h01, 8'h02, 24'h33, 1, nak);
    chk(24'(nak), 24'h1);
    chk(24'({vb, va}), 24'h5a);
    wrc(8'h07, 24'h77, 1);
    rdc(8'h07, 1, 24'h0);
    dlsc_host_i.rd(DEV, 8'h02, 1, d, nak);
    chk(d, 24'h5a);
    $display("test refuse done");
    close_out();
  end

  initial begin
    #3000000;
    bad_count++;
    $display("watchdog expired at %0t", $time);
    close_out();
  end
endmodule
